// ### src/ebcs_pkg.sv
// Shared constants and types of the expansion bus controller.
package ebcs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_IRQ_ACK    = 32'h25FE00A8;
  localparam logic [31:0] ADDR_CFG_LOW    = 32'h25FE00B0;
  localparam logic [31:0] ADDR_CFG_HIGH   = 32'h25FE00B4;
  localparam logic [31:0] ADDR_EVT_STATUS = 32'h25FE00B8;
  localparam logic [31:0] ADDR_EVT_MASK   = 32'h25FE00BC;
  localparam logic [31:0] ADDR_CLASS_WORD = 32'h25FE00C0;

  // ----------------------------------------------------------------
  // Decoded register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_IACK  = 3'h1;
  localparam logic [2:0] SEL_CLO   = 3'h2;
  localparam logic [2:0] SEL_CHI   = 3'h3;
  localparam logic [2:0] SEL_STAT  = 3'h4;
  localparam logic [2:0] SEL_MASK  = 3'h5;
  localparam logic [2:0] SEL_CLASS = 3'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          IRQ_EN_BIT      = 0;
  localparam int          PREFETCH_BIT    = 31;
  localparam int          WRITE_IDLE_BIT  = 30;
  localparam int          READ_IDLE_BIT   = 29;
  localparam int          EXT_WAIT_BIT    = 28;
  localparam int          BURST_WAIT_LSB  = 24;
  localparam int          NORMAL_WAIT_LSB = 20;
  localparam int          BOUNDARY_LSB    = 18;
  localparam int          WIDTH_BIT       = 16;
  localparam int          EVT_ACK_DONE    = 0;
  localparam int          EVT_IRQ_BLOCKED = 1;
  localparam logic [31:0] IRQ_ACK_RESET   = 32'h00000000;
  localparam logic [31:0] CFG_RESET       = 32'h00000000;
  localparam logic [1:0]  EVT_RESET       = 2'h0;

  // ----------------------------------------------------------------
  // Bus encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] BND_NONE     = 2'h0;
  localparam logic [1:0] BND_4        = 2'h1;
  localparam logic [1:0] BND_256      = 2'h2;
  localparam logic [1:0] SPACE_FIRST  = 2'h0;
  localparam logic [1:0] SPACE_DUMMY  = 2'h3;
  localparam logic [3:0] ACK_WAIT     = 4'h1;
  localparam logic [2:0] CS_IDLE      = 3'h7;

  typedef enum logic [1:0] {
    EBCS_IDLE   = 2'b00,
    EBCS_STROBE = 2'b01,
    EBCS_GAP    = 2'b11
  } ebcs_state_e;

endpackage

// ### src/ebcs_sync.sv
// Three-stage input synchroniser that accepts a change once two stages agree.
`timescale 1ns/10ps
module ebcs_sync
  import ebcs_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  // Clean side
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ebcs_sync_s;

  ebcs_sync_s r;
  ebcs_sync_s next_r;
  logic [W-1:0] agree_val;

  // The first stage feeds only the second, so metastability cannot leak.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign agree_val[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
    end
  endgenerate

  always_comb begin
    next_r    = r;
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = agree_val;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= {RST, RST, RST, RST};
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.q;

endmodule

// ### src/ebcs_ctrl.sv
// Expansion bus controller: register file, space decode and first-space timing.
// Operation
// - Four spaces; three drive own chip select, dummy space drives none.
// - Enable bit at bit 0 of acknowledge register, readable and writable.
// - Requested interrupt while enabled runs acknowledge cycle fetching 16-bit word.
// - Acknowledge cycle clears the enable bit; software must set it again.
// - Prefetch bit 31 reads next sequential address ahead; others unshortened.
// - Write idle bit 30 adds one idle clock after writes only.
// - Read idle bit 29 adds one idle clock after reads only.
// - External wait bit 28 stretches access while wait input low.
// - Burst wait count bits 27..24 adds waits to each burst cycle.
// - Normal wait count bits 23..20 adds waits to normal accesses.
// - Zero wait count adds no waits and skips wait sampling.
// - Burst boundary bits 19..18: none, 4, 256, unbounded.
// - Width bit 16 at zero gives 16-bit transfers.
// - Acknowledge register resets to zero, interrupts invalid.
// - Both configuration words reset to zero.
`timescale 1ns/10ps
module ebcs_ctrl
  import ebcs_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Internal access port
  input  wire logic        acc_req,
  input  wire logic [25:0] acc_addr,
  input  wire logic        acc_write,
  input  wire logic [15:0] acc_wdata,
  output logic             acc_done,
  output logic      [15:0] acc_rdata,
  // Expansion bus pins
  output logic      [25:0] ext_addr,
  output logic      [2:0]  ext_cs_n,
  output logic             ext_rd_n,
  output logic             ext_wr_n,
  output logic             ext_iack_n,
  input  wire logic [15:0] ext_data_in,
  output logic      [15:0] ext_data_out,
  output logic             ext_data_oe_n,
  input  wire logic        ext_wait_n,
  input  wire logic        ext_irq_n,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    ebcs_state_e st;
    logic        irq_en;
    logic [31:0] cfg_lo;
    logic [31:0] cfg_hi;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [15:0] cls;
    logic        dp_valid;
    logic        dp_write;
    logic [2:0]  dp_sel;
    logic [31:0] rdata;
    logic [25:0] addr;
    logic [25:0] eaddr;
    logic [2:0]  cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        iack_n;
    logic [15:0] dout;
    logic        doe_n;
    logic [3:0]  wcnt;
    logic        sample;
    logic        is_ack;
    logic        is_pf;
    logic        is_write;
    logic        wide8;
    logic        byte_hi;
    logic [1:0]  space;
    logic [15:0] wdata;
    logic [7:0]  lo_byte;
    logic        pf_go;
    logic        pf_valid;
    logic [25:0] pf_addr;
    logic [15:0] pf_data;
    logic        last_valid;
    logic [25:0] last_addr;
    logic        done;
    logic [15:0] acc_rd;
  } ebcs_ctrl_s;

  ebcs_ctrl_s r;
  ebcs_ctrl_s next_r;
  logic       wait_n_s;
  logic       irq_n_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ebcs_sync #(.W(2), .RST(2'h3)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .pin_in   ({ext_wait_n, ext_irq_n}),
    .sync_out ({wait_n_s, irq_n_s})
  );

  // ----------------------------------------------------------------
  // Control and datapath
  // ----------------------------------------------------------------
  logic        go;
  logic        go_ack;
  logic        go_pf;
  logic        go_write;
  logic        go_burst;
  logic [25:0] go_addr;
  logic [1:0]  go_space;
  logic [3:0]  go_wait;
  logic [15:0] rd_word;
  logic        finish;
  logic        sw_en_wr;
  logic [2:0]  sel;
  logic [1:0]  bnd;
  logic        in_block;

  always_comb begin
    next_r   = r;
    next_r.done = 1'b0;
    go       = 1'b0;
    go_ack   = 1'b0;
    go_pf    = 1'b0;
    go_write = 1'b0;
    go_addr  = acc_addr;
    go_space = SPACE_FIRST;
    go_burst = 1'b0;
    go_wait  = 4'h0;
    finish   = 1'b0;
    rd_word  = ext_data_in;
    sel      = SEL_NONE;
    bnd      = r.cfg_lo[BOUNDARY_LSB +: 2];
    in_block = 1'b0;
    sw_en_wr = r.dp_valid && r.dp_write && (r.dp_sel == SEL_IACK);

    // Events stick until written one; a new event beats the clear.
    if (r.dp_valid && r.dp_write && (r.dp_sel == SEL_STAT)) begin
      next_r.stat = r.stat & ~hwdata[1:0];
    end
    if (!irq_n_s && !r.irq_en) begin
      next_r.stat[EVT_IRQ_BLOCKED] = 1'b1;
    end

    unique case (r.st)
      EBCS_IDLE: begin
        if (r.irq_en && !irq_n_s) begin
          go     = 1'b1;
          go_ack = 1'b1;
        end else if (r.pf_go) begin
          go      = 1'b1;
          go_pf   = 1'b1;
          go_addr = 26'(r.last_addr + 26'h1);
        end else if (acc_req && !r.done) begin
          if (!acc_write && r.pf_valid && (acc_addr == r.pf_addr) && r.cfg_lo[PREFETCH_BIT]) begin
            next_r.done      = 1'b1;
            next_r.acc_rd    = r.pf_data;
            next_r.pf_valid  = 1'b0;
            next_r.pf_go     = 1'b1;
            next_r.last_addr = acc_addr;
          end else begin
            go       = 1'b1;
            go_write = acc_write;
          end
        end
      end
      EBCS_STROBE: begin
        if (r.wcnt != 4'h0) begin
          next_r.wcnt = r.wcnt - 4'h1;
        end else if (!(r.sample && !wait_n_s)) begin
          finish = 1'b1;
        end
      end
      EBCS_GAP: begin
        next_r.st = EBCS_IDLE;
      end
      default: begin
        next_r.st = EBCS_IDLE;
      end
    endcase

    // Launch a new cycle on the expansion bus.
    if (go) begin
      go_space = go_ack ? SPACE_DUMMY : go_addr[25:24];
      case (bnd)
        BND_NONE: in_block = 1'b0;
        BND_4:    in_block = (go_addr[25:2] == r.last_addr[25:2]);
        BND_256:  in_block = (go_addr[25:8] == r.last_addr[25:8]);
        default:  in_block = 1'b1;
      endcase
      go_burst = r.last_valid && in_block && (go_addr == 26'(r.last_addr + 26'h1));
      if (go_ack) begin
        go_wait = ACK_WAIT;
      end else if (go_space == SPACE_FIRST) begin
        go_wait = go_burst ? r.cfg_lo[BURST_WAIT_LSB +: 4] : r.cfg_lo[NORMAL_WAIT_LSB +: 4];
      end
      next_r.st       = EBCS_STROBE;
      next_r.addr     = go_addr;
      next_r.space    = go_space;
      next_r.is_ack   = go_ack;
      next_r.is_pf    = go_pf;
      next_r.is_write = go_write;
      next_r.wdata    = acc_wdata;
      next_r.wcnt     = go_wait;
      next_r.sample   = (go_wait != 4'h0) && (go_ack || (go_space == SPACE_FIRST)) &&
                        r.cfg_lo[EXT_WAIT_BIT];
      next_r.wide8    = !go_ack && (go_space == SPACE_FIRST) && r.cfg_lo[WIDTH_BIT];
      next_r.byte_hi  = 1'b0;
      next_r.pf_go    = 1'b0;
      next_r.eaddr    = next_r.wide8 ? {go_addr[24:0], 1'b0} : go_addr;
      next_r.cs_n     = CS_IDLE;
      if (go_space != SPACE_DUMMY) begin
        next_r.cs_n[go_space] = 1'b0;
      end
      next_r.iack_n   = !go_ack;
      next_r.rd_n     = go_write;
      next_r.wr_n     = !go_write;
      next_r.doe_n    = !go_write;
      next_r.dout     = acc_wdata;
      if (go_write) begin
        next_r.pf_valid = 1'b0;
      end
      if (!go_ack) begin
        next_r.last_valid = (go_space == SPACE_FIRST);
        next_r.last_addr  = go_addr;
      end
    end

    // End of a transfer: an 8-bit space takes a second byte first.
    if (finish) begin
      if (r.wide8 && !r.byte_hi) begin
        next_r.byte_hi = 1'b1;
        next_r.lo_byte = ext_data_in[7:0];
        next_r.eaddr   = {r.addr[24:0], 1'b1};
        next_r.dout    = {8'h00, r.wdata[15:8]};
        next_r.wcnt    = r.cfg_lo[NORMAL_WAIT_LSB +: 4];
      end else begin
        rd_word        = r.wide8 ? {ext_data_in[7:0], r.lo_byte} : ext_data_in;
        next_r.cs_n    = CS_IDLE;
        next_r.rd_n    = 1'b1;
        next_r.wr_n    = 1'b1;
        next_r.iack_n  = 1'b1;
        next_r.doe_n   = 1'b1;
        next_r.st      = EBCS_IDLE;
        if ((r.space == SPACE_FIRST) && !r.is_ack &&
            ((r.is_write && r.cfg_lo[WRITE_IDLE_BIT]) || (!r.is_write && r.cfg_lo[READ_IDLE_BIT]))) begin
          next_r.st = EBCS_GAP;
        end
        if (r.is_ack) begin
          next_r.cls    = rd_word;
          next_r.irq_en = 1'b0;
          next_r.stat[EVT_ACK_DONE] = 1'b1;
        end else if (r.is_pf) begin
          next_r.pf_valid = 1'b1;
          next_r.pf_addr  = r.addr;
          next_r.pf_data  = rd_word;
        end else begin
          next_r.done   = 1'b1;
          next_r.acc_rd = r.is_write ? 16'h0000 : rd_word;
          next_r.pf_go  = !r.is_write && (r.space == SPACE_FIRST) && r.cfg_lo[PREFETCH_BIT];
        end
      end
    end

    // Register writes land in the data phase.
    if (sw_en_wr) begin
      next_r.irq_en = hwdata[IRQ_EN_BIT];
    end
    if (r.dp_valid && r.dp_write) begin
      case (r.dp_sel)
        SEL_CLO:  next_r.cfg_lo = hwdata;
        SEL_CHI:  next_r.cfg_hi = hwdata;
        SEL_MASK: next_r.mask   = hwdata[1:0];
        default:  ;
      endcase
    end

    // Address phase: decode and prepare read data from updated values.
    next_r.dp_valid = hsel && htrans[1] && hready;
    next_r.dp_write = hwrite;
    if (haddr == ADDR_IRQ_ACK) sel = SEL_IACK;
    if (haddr == ADDR_CFG_LOW) sel = SEL_CLO;
    if (haddr == ADDR_CFG_HIGH) sel = SEL_CHI;
    if (haddr == ADDR_EVT_STATUS) sel = SEL_STAT;
    if (haddr == ADDR_EVT_MASK) sel = SEL_MASK;
    if (haddr == ADDR_CLASS_WORD) sel = SEL_CLASS;
    next_r.dp_sel = sel;
    if (next_r.dp_valid && !hwrite) begin
      case (sel)
        SEL_IACK:  next_r.rdata = {31'h0, next_r.irq_en};
        SEL_STAT:  next_r.rdata = {30'h0, next_r.stat};
        SEL_MASK:  next_r.rdata = {30'h0, next_r.mask};
        SEL_CLASS: next_r.rdata = {16'h0000, next_r.cls};
        default:   next_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r        <= '0;
      r.st     <= EBCS_IDLE;
      r.irq_en <= IRQ_ACK_RESET[IRQ_EN_BIT];
      r.cfg_lo <= CFG_RESET;
      r.cfg_hi <= CFG_RESET;
      r.stat   <= EVT_RESET;
      r.mask   <= EVT_RESET;
      r.cs_n   <= CS_IDLE;
      r.rd_n   <= 1'b1;
      r.wr_n   <= 1'b1;
      r.iack_n <= 1'b1;
      r.doe_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = r.rdata;
  assign acc_done      = r.done;
  assign acc_rdata     = r.acc_rd;
  assign ext_addr      = r.eaddr;
  assign ext_cs_n      = r.cs_n;
  assign ext_rd_n      = r.rd_n;
  assign ext_wr_n      = r.wr_n;
  assign ext_iack_n    = r.iack_n;
  assign ext_data_out  = r.dout;
  assign ext_data_oe_n = r.doe_n;
  assign irq           = |(r.stat & r.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic end_last;
  assign end_last = finish && !(r.wide8 && !r.byte_hi);

  sequence s_gap_then_idle;
    (r.st == EBCS_GAP) ##1 (r.st == EBCS_IDLE);
  endsequence

  chk_dummy_no_cs: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r.st == EBCS_STROBE && r.space == SPACE_DUMMY) |-> (ext_cs_n == CS_IDLE))
    else $error("Dummy space drove a chip select.");

  chk_enable_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sw_en_wr) |=> (r.irq_en == $past(hwdata[0])))
    else $error("Enable bit did not take written value.");

  chk_ack_launch: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r.st == EBCS_IDLE && r.irq_en && !irq_n_s) |=> (!ext_iack_n && ext_rd_n == 1'b0))
    else $error("Acknowledge cycle did not start.");

  chk_ack_clears_en: assert property (@(posedge sys_clk) disable iff (!resetn)
    (end_last && r.is_ack && !sw_en_wr) |=> (!r.irq_en && r.stat[EVT_ACK_DONE] && r.cls == $past(ext_data_in)))
    else $error("Acknowledge did not clear enable or keep word.");

  chk_write_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (end_last && r.is_write && r.space == SPACE_FIRST && r.cfg_lo[WRITE_IDLE_BIT]) |=> s_gap_then_idle)
    else $error("Idle clock after write missing.");

  chk_read_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (end_last && !r.is_write && !r.is_ack && r.space == SPACE_FIRST && !r.cfg_lo[READ_IDLE_BIT])
    |=> (r.st != EBCS_GAP))
    else $error("Idle clock after read without the bit.");

  chk_read_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (end_last && !r.is_write && !r.is_ack && r.space == SPACE_FIRST && r.cfg_lo[READ_IDLE_BIT])
    |=> s_gap_then_idle)
    else $error("Idle clock after read missing.");

  chk_zero_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r.st == EBCS_STROBE && r.wcnt == 4'h0 && !r.sample) |-> finish)
    else $error("Zero wait access was stretched.");

  chk_normal_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    (go && !go_ack && !go_burst && go_addr[25:24] == SPACE_FIRST)
    |=> (r.wcnt == $past(r.cfg_lo[NORMAL_WAIT_LSB +: 4])))
    else $error("Normal wait count not loaded.");

  chk_byte_split: assert property (@(posedge sys_clk) disable iff (!resetn)
    (finish && r.wide8 && !r.byte_hi) |=> (r.st == EBCS_STROBE && r.byte_hi && ext_addr[0]))
    else $error("Second byte of 8-bit access missing.");

  chk_prefetch_go: assert property (@(posedge sys_clk) disable iff (!resetn)
    (end_last && !r.is_write && !r.is_ack && !r.is_pf && r.space == SPACE_FIRST &&
     r.cfg_lo[PREFETCH_BIT] && irq_n_s) |-> ##[1:3] (r.st == EBCS_STROBE && r.is_pf))
    else $error("Prefetch read did not follow.");

endmodule

// ### verification/ebcs_dev_model.sv
// Behavioural expansion bus device: word source, wait stretcher and interrupt requester.
`timescale 1ns/10ps
module ebcs_dev_model
  import ebcs_pkg::*;
#(
  parameter logic [15:0] CLASS_WORD = 16'h3C5A
) (
  // Clock
  input  wire logic        sys_clk,
  // Bus pins
  input  wire logic [25:0] ext_addr,
  input  wire logic [2:0]  ext_cs_n,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic        ext_iack_n,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_data_oe_n,
  output logic      [15:0] ext_data_in,
  output logic             ext_wait_n,
  output logic             ext_irq_n,
  // Bench control
  input  wire logic        irq_req,
  input  wire logic [3:0]  stall,
  output logic      [15:0] last_wdata
);
  logic [15:0] last_q = 16'h0000;
  logic [3:0]  cnt    = 4'h0;
  logic        pend   = 1'b0;
  logic        busy_q = 1'b0;
  wire         busy   = !ext_rd_n || !ext_wr_n;
  wire         ack_rd = !ext_iack_n && !ext_rd_n;
  wire         sel_rd = !ext_rd_n && ext_cs_n != CS_IDLE;

  function automatic logic [15:0] data_of(input logic [25:0] a);
    return a[15:0] ^ 16'hA5C3;
  endfunction

  // A released bus shows the inverse of its last value, so a stale word never matches.
  assign ext_data_in = ack_rd ? CLASS_WORD : sel_rd ? data_of(ext_addr) : ~last_q;
  assign ext_wait_n  = cnt == 4'h0;
  assign ext_irq_n   = !pend;
  initial last_wdata = 16'h0000;

  always @(posedge sys_clk) begin
    busy_q <= busy;
    last_q <= ext_data_in;
    if (busy && !busy_q) begin
      cnt <= stall;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    if (irq_req) begin
      pend <= 1'b1;
    end else if (ack_rd) begin
      pend <= 1'b0;
    end
    if (!ext_wr_n && !ext_data_oe_n) begin
      last_wdata <= ext_data_out;
    end
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench of the expansion bus controller against a behavioural bus device.
`timescale 1ns/10ps
module tb_top;
  import ebcs_pkg::*;
  // Arbitrary classification word supplied by the model.
  localparam logic [15:0] CLASS_VAL = 16'h3C5A;
  logic        sys_clk, resetn, hsel, hwrite, acc_req, acc_write, irq_req, hreadyout, hresp;
  logic        acc_done, ext_rd_n, ext_wr_n, ext_iack_n, ext_data_oe_n, ext_wait_n, ext_irq_n, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ext_cs_n, cs_seen;
  logic [3:0]  stall, w;
  logic [15:0] acc_wdata, acc_rdata, ext_data_in, ext_data_out, last_wdata, r16, d;
  logic [25:0] acc_addr, ext_addr, a;
  logic [25:0] ba [3];
  logic [31:0] haddr, hwdata, hrdata, r32, seed;
  int          failures, check_count, run, slen;

  ebcs_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
    .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_iack_n(ext_iack_n),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
    .ext_wait_n(ext_wait_n), .ext_irq_n(ext_irq_n), .irq(irq));
  ebcs_dev_model #(.CLASS_WORD(CLASS_VAL)) dev_u (.sys_clk(sys_clk), .ext_addr(ext_addr),
    .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_iack_n(ext_iack_n),
    .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n), .ext_data_in(ext_data_in),
    .ext_wait_n(ext_wait_n), .ext_irq_n(ext_irq_n), .irq_req(irq_req), .stall(stall),
    .last_wdata(last_wdata));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Strobe run length and the chip selects seen during it.
  always @(posedge sys_clk) begin
    if (!ext_rd_n || !ext_wr_n) begin
      run = run + 1;
      cs_seen = cs_seen & ext_cs_n;
    end else if (run != 0) begin
      slen = run;
      run = 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] exp8(input logic [25:0] x);
    logic [15:0] lo, hi;
    lo = dev_u.data_of({x[24:0], 1'b0});
    hi = dev_u.data_of({x[24:0], 1'b1});
    return {hi[7:0], lo[7:0]};
  endfunction

  task automatic finish_test();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up();
    failures++;
    finish_test();
  endtask

  task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= ad;
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dt;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    r32 = hrdata;
    if (n >= 100) give_up();
  endtask

  task automatic rdchk(input string what, input logic [31:0] ad, input logic [31:0] exp);
    ahb(1'b0, ad, 32'h00000000);
    check(what, r32, exp);
    check("response code", {31'h0, hresp}, 32'h0);
  endtask

  task automatic acc(input logic [25:0] ad, input logic wr, input logic [15:0] dt);
    int n;
    n = 0;
    cs_seen = 3'h7;
    acc_req   <= 1'b1;
    acc_addr  <= ad;
    acc_write <= wr;
    acc_wdata <= dt;
    do begin
      @(posedge sys_clk);
      n++;
    end while (acc_done !== 1'b1 && n < 300);
    r16 = acc_rdata;
    acc_req <= 1'b0;
    @(posedge sys_clk);
    if (n >= 300) give_up();
  endtask

  initial begin
    {resetn, hsel, hwrite, acc_req, acc_write, irq_req} = 6'h00;
    {htrans, stall, acc_wdata, acc_addr, haddr, hwdata} = 0;
    hsize = 3'h2;
    seed = 32'h00000052;
    {failures, check_count, run, slen} = 0;
    cs_seen = 3'h7;
    ba = '{26'h00000FF, 26'h0000100, 26'h0000101};
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("irq at reset", {31'h0, irq}, 32'h0);
    rdchk("enable reset", ADDR_IRQ_ACK, IRQ_ACK_RESET);
    rdchk("cfg low reset", ADDR_CFG_LOW, CFG_RESET);
    rdchk("cfg high reset", ADDR_CFG_HIGH, CFG_RESET);
    rdchk("unmapped read", 32'h25FE00AC, 32'h0);
    ahb(1'b1, ADDR_IRQ_ACK, 32'hFFFFFFFF);
    rdchk("enable set", ADDR_IRQ_ACK, 32'h1);
    ahb(1'b1, ADDR_IRQ_ACK, 32'hFFFFFFFE);
    rdchk("enable clear", ADDR_IRQ_ACK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'(rnd());
      a = {2'b00, 24'(rnd())};
      ahb(1'b1, ADDR_CFG_LOW, {8'h00, w, 20'h0});
      acc(a, 1'b0, 16'h0000);
      check("normal strobe length", 32'(slen), 32'(w) + 1);
      check("normal read data", {16'h0, r16}, {16'h0, dev_u.data_of(a)});
      check("first space select", {29'h0, cs_seen}, 32'h6);
    end
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, ADDR_CFG_LOW, {4'h0, 4'h5, 4'h2, 2'(c), 18'h0});
      for (int k = 0; k < 3; k++) begin
        acc(ba[k], 1'b0, 16'h0000);
        check("burst strobe length", 32'(slen), ((k == 1 && c == 3) || (k == 2 && c != 0)) ? 6 : 3);
      end
    end
    stall <= 4'h8;
    ahb(1'b1, ADDR_CFG_LOW, {8'h00, 4'h6, 20'h0});
    acc(26'h0000040, 1'b0, 16'h0000);
    check("wait ignored", 32'(slen), 32'h7);
    ahb(1'b1, ADDR_CFG_LOW, {4'h1, 4'h0, 4'h6, 20'h0});
    acc(26'h0000080, 1'b0, 16'h0000);
    check("wait honoured", {31'h0, slen > 7}, 32'h1);
    stall <= 4'h0;
    ahb(1'b1, ADDR_CFG_LOW, 32'h00010000);
    a = {2'b00, 24'(rnd())};
    acc(a, 1'b0, 16'h0000);
    check("byte wide read", {16'h0, r16}, {16'h0, exp8(a)});
    ahb(1'b1, ADDR_CFG_LOW, {4'hE, 28'h0});
    acc(26'h0000300, 1'b0, 16'h0000);
    acc(26'h0000301, 1'b0, 16'h0000);
    check("prefetch read data", {16'h0, r16}, {16'h0, dev_u.data_of(26'h0000301)});
    acc(26'h0000310, 1'b1, 16'hC3A5);
    check("write idle data", {16'h0, last_wdata}, 32'h0000C3A5);
    ahb(1'b1, ADDR_CFG_LOW, 32'h00000000);
    d = 16'(rnd());
    acc(26'h0000200, 1'b1, d);
    check("write data", {16'h0, last_wdata}, {16'h0, d});
    acc({2'b11, 24'h000123}, 1'b1, d);
    check("dummy no select", {29'h0, cs_seen}, 32'h7);
    ahb(1'b1, ADDR_EVT_MASK, 32'h1);
    ahb(1'b1, ADDR_IRQ_ACK, 32'h1);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    for (int n = 0; irq !== 1'b1; n++) begin
      if (n > 200) give_up();
      @(posedge sys_clk);
    end
    rdchk("class word", ADDR_CLASS_WORD, {16'h0, CLASS_VAL});
    rdchk("enable after ack", ADDR_IRQ_ACK, 32'h0);
    ahb(1'b0, ADDR_EVT_STATUS, 32'h0);
    check("ack event", {31'h0, r32[EVT_ACK_DONE]}, 32'h1);
    check("blocked event", {31'h0, r32[EVT_IRQ_BLOCKED]}, 32'h1);
    ahb(1'b1, ADDR_EVT_MASK, 32'h0);
    @(posedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    ahb(1'b1, ADDR_EVT_MASK, 32'h1);
    @(posedge sys_clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    ahb(1'b1, ADDR_EVT_STATUS, 32'h3);
    @(posedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    ahb(1'b1, ADDR_IRQ_ACK, 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdchk("enable after reset", ADDR_IRQ_ACK, IRQ_ACK_RESET);
    rdchk("mask after reset", ADDR_EVT_MASK, 32'h0);
    finish_test();
  end
endmodule
